// ---- verif/hcc_bc_model.sv ----
`timescale 1ns/1ps
module hcc_ctl_model
  import hcc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reply_in,
  input  wire logic        term_in,
  input  wire logic [15:0] in_data_in,
  output logic             out_strobe_out,
  output logic             in_req_out,
  output logic      [15:0] out_data_out,
  output logic      [1:0]  out_parity_out
);
  initial
  begin
    out_strobe_out = 1'b0;
    in_req_out     = 1'b0;
    out_data_out   = 16'hffff;
    out_parity_out = 2'b00;
  end

  // The strobe stands one clock of 40 ns, inside the allowed width; the
  // coupler still samples it high at the following edge.
  task automatic xfer(input logic is_out, input logic [15:0] w,
                      output logic rp, output logic tm,
                      output logic [15:0] got);
    int n;
    rp  = 1'b0;
    tm  = 1'b0;
    got = 16'h0000;
    n   = 0;
    @(posedge clk_in);
    out_data_out   <= w;
    out_parity_out <= {~^w[15:8], ~^w[7:0]};
    if (is_out)
      out_strobe_out <= 1'b1;
    else
      in_req_out <= 1'b1;
    while (!rp && !tm && n < 40)
    begin
      @(posedge clk_in);
      n++;
      if (n == 1)
      begin
        out_strobe_out <= 1'b0;
        in_req_out     <= 1'b0;
      end
      rp  = reply_in;
      tm  = term_in;
      got = in_data_in;
    end
    if (is_out)
      repeat (IN_HOLD_CYC) @(posedge clk_in);
    out_data_out <= ~w;
  endtask : xfer
endmodule : hcc_ctl_model

// ---- verif/tb_host_channel_coupler.sv ----
`timescale 1ns/1ps
module tb_host_channel_coupler;
  import hcc_pkg::*;
  localparam logic [3:0] EQ   = 4'h6;
  localparam logic [1:0] NONE = 2'b00;
  localparam logic [1:0] OK   = 2'b01;
  localparam logic [1:0] NO   = 2'b10;
  logic        clk, rst, h_rd, h_wr, h_prot, prot_sw, mclr;
  logic        h_oe, h_rep, h_rej, h_int, c_rdy, c_rep, c_trm;
  logic        o_stb, i_req;
  logic [1:0]  o_par;
  logic [15:0] h_addr, h_wd, sys_st, trn_st, rdat;
  logic [15:0] h_dout, ctl_in, c_st, o_dat;
  int          n_errors = 0;
  int          n_tests = 0;

  hcc_coupler i_hcc_coupler (
    .CLK_IN(clk), .RESET_IN(rst), .HOST_RD_IN(h_rd), .HOST_WR_IN(h_wr),
    .HOST_PROT_IN(h_prot), .HOST_ADDR_IN(h_addr), .HOST_DATA_IN(h_wd),
    .HOST_DATA_OUT(h_dout), .HOST_DATA_OE_OUT(h_oe),
    .HOST_REPLY_OUT(h_rep), .HOST_REJECT_OUT(h_rej), .HOST_INT_OUT(h_int),
    .EQUIP_SEL_IN(EQ), .PROTECT_SW_IN(prot_sw),
    .REPEATED_MASTER_CLEAR_IN(mclr), .OUTPUT_WORD_STROBE_IN(o_stb),
    .INPUT_WORD_REQUEST_IN(i_req), .CTL_OUT_DATA_IN(o_dat),
    .CTL_OUT_PARITY_IN(o_par), .COUPLER_READY_LEVEL_OUT(c_rdy),
    .COUPLER_REPLY_PULSE_OUT(c_rep), .COUPLER_TERMINATE_PULSE_OUT(c_trm),
    .CTL_IN_DATA_OUT(ctl_in), .SYS_STATUS_IN(sys_st),
    .TRN_STATUS_IN(trn_st), .COUPLER_STATUS_OUT(c_st));

  hcc_ctl_model i_hcc_ctl_model (
    .clk_in(clk), .reply_in(c_rep), .term_in(c_trm), .in_data_in(ctl_in),
    .out_strobe_out(o_stb), .in_req_out(i_req), .out_data_out(o_dat),
    .out_parity_out(o_par));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic give_verdict();
    $display("Errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk_w(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_w

  task automatic chk_b(input string nm, input logic e, input logic g);
    chk_w(nm, {15'h0000, e}, {15'h0000, g});
  endtask : chk_b

  function automatic logic [15:0] a(input logic [3:0] d);
    return {5'h00, EQ, 3'h0, d};
  endfunction : a

  // The request level is held until an answer is sampled or HOST_ANSWER_CYC clocks pass, then dropped.
  task automatic host(input logic rd, input logic [15:0] adr,
                      input logic [15:0] wd, input logic [1:0] exp);
    int   n;
    logic rp;
    logic rj;
    n  = 0;
    rp = 1'b0;
    rj = 1'b0;
    @(posedge clk);
    h_rd   <= rd;
    h_wr   <= ~rd;
    h_addr <= adr;
    h_wd   <= wd;
    while (!rp && !rj && n < HOST_ANSWER_CYC)
    begin
      @(posedge clk);
      n++;
      rp   = h_rep;
      rj   = h_rej;
      rdat = h_dout;
      if (rp && rd)
        chk_b("host oe", 1'b1, h_oe);
    end
    h_rd <= 1'b0;
    h_wr <= 1'b0;
    chk_w("host answer", {14'h0000, exp}, {14'h0000, rj, rp});
    if (exp != NONE && !rp && !rj)
      give_verdict();
    repeat (6) @(posedge clk);
  endtask : host

  task automatic xfer_ctl(input logic is_out, input logic [15:0] w,
                    input logic [1:0] exp);
    logic        rp;
    logic        tm;
    logic [15:0] g;
    i_hcc_ctl_model.xfer(is_out, w, rp, tm, g);
    rdat = g;
    chk_w("ctl answer", {14'h0000, exp}, {14'h0000, tm, rp});
    if (!rp && !tm)
      give_verdict();
    repeat (3) @(posedge clk);
  endtask : xfer_ctl

  task automatic pulse_sys(input logic [15:0] v);
    sys_st <= v;
    repeat (4) @(posedge clk);
    sys_st <= 16'h0001;
    repeat (4) @(posedge clk);
  endtask : pulse_sys

  task automatic t_addr();
    host(1'b1, {5'h00, ~EQ, 3'h0, DIR_STATUS}, 16'h0000, NONE);
    host(1'b1, a(DIR_STATUS) | 16'h0800, 16'h0000, NONE);
    host(1'b1, a(DIR_STATUS) | 16'h8000, 16'h0000, NONE);
    host(1'b1, a(DIR_STATUS), 16'h0000, OK);
  endtask : t_addr

  task automatic t_prot();
    prot_sw <= 1'b1;
    host(1'b1, a(DIR_STATUS), 16'h0000, NO);
    h_prot <= 1'b1;
    host(1'b1, a(DIR_STATUS), 16'h0000, OK);
    prot_sw <= 1'b0;
    h_prot  <= 1'b0;
  endtask : t_prot

  task automatic t_idle();
    host(1'b0, a(DIR_DATA), 16'h1234, NO);
    host(1'b1, a(DIR_CTRL), 16'h0000, NO);
    host(1'b0, a(DIR_STATUS), 16'h0000, NO);
    host(1'b0, a(4'h5), 16'h0000, NO);
    chk_b("ready", 1'b0, c_rdy);
    xfer_ctl(1'b1, 16'h0f0f, NO);
  endtask : t_idle

  task automatic t_write();
    pulse_sys(16'h0005);
    host(1'b0, a(DIR_CTRL), 16'h0011, OK);
    chk_b("host int", 1'b1, h_int);
    sys_st <= 16'h0000;
    host(1'b0, a(DIR_DATA), 16'h5a3c, NO);
    sys_st <= 16'h0001;
    host(1'b0, a(DIR_DATA), 16'h5a3c, OK);
    chk_b("host int", 1'b0, h_int);
    chk_b("ready", 1'b1, c_rdy);
    host(1'b1, a(DIR_STATUS), 16'h0000, OK);
    chk_w("status", 16'h0038, rdat);
    chk_w("ctl status", 16'hc600, c_st);
    xfer_ctl(1'b0, 16'h0000, OK);
    chk_w("ctl word", 16'h5a3c, rdat);
    chk_w("ctl status", 16'h0000, c_st);
    chk_b("host int", 1'b1, h_int);
  endtask : t_write

  task automatic t_read();
    host(1'b0, a(DIR_CTRL), 16'h0030, OK);
    xfer_ctl(1'b1, 16'hc3e1, OK);
    host(1'b1, a(DIR_DATA), 16'h0000, OK);
    chk_w("host word", 16'hc3e1, rdat);
    host(1'b1, a(DIR_DATA), 16'h0000, NO);
  endtask : t_read

  task automatic t_eop();
    host(1'b0, a(DIR_CTRL), 16'h000a, OK);
    chk_b("ready", 1'b0, c_rdy);
    xfer_ctl(1'b0, 16'h0000, NO);
    chk_b("host int", 1'b1, h_int);
    host(1'b0, a(DIR_CTRL), 16'h0000, OK);
    chk_b("host int", 1'b0, h_int);
    sys_st <= 16'h0003;
    repeat (4) @(posedge clk);
    host(1'b0, a(DIR_CTRL), 16'h0002, OK);
    chk_b("host int", 1'b0, h_int);
    sys_st <= 16'h0001;
  endtask : t_eop

  task automatic t_alarm();
    host(1'b0, a(DIR_CTRL), 16'h0004, OK);
    trn_st <= 16'h0001;
    repeat (4) @(posedge clk);
    chk_b("host int", 1'b1, h_int);
    host(1'b1, a(DIR_STATUS), 16'h0000, OK);
    chk_w("status", 16'h010c, rdat);
    host(1'b0, a(DIR_CTRL), 16'h0000, OK);
    chk_b("host int", 1'b0, h_int);
    trn_st <= 16'h0000;
  endtask : t_alarm

  task automatic t_auto();
    host(1'b0, a(DIR_AUTOLOAD), 16'h0000, OK);
    host(1'b1, a(DIR_STATUS), 16'h0000, OK);
    chk_w("status", 16'h0048, rdat);
    host(1'b0, a(DIR_AUTOLOAD), 16'h7e81, OK);
    host(1'b1, a(DIR_AUTOLOAD), 16'h0000, NO);
    host(1'b0, a(DIR_AUTOLOAD), 16'h0000, NO);
  endtask : t_auto

  task automatic t_mclr();
    mclr <= 1'b1;
    repeat (4) @(posedge clk);
    mclr <= 1'b0;
    repeat (4) @(posedge clk);
    chk_b("clear flag", 1'b1, c_st[CS_MCLR]);
    host(1'b1, a(DIR_STATUS), 16'h0000, OK);
    chk_w("status", 16'h0008, rdat);
    pulse_sys(16'h0005);
    chk_w("ctl status", 16'h0000, c_st);
  endtask : t_mclr

  initial
  begin
    rst     = 1'b1;
    h_rd    = 1'b0;
    h_wr    = 1'b0;
    h_prot  = 1'b0;
    prot_sw = 1'b0;
    mclr    = 1'b0;
    h_addr  = 16'h0000;
    h_wd    = 16'h0000;
    sys_st  = 16'h0001;
    trn_st  = 16'h0000;
    rdat    = 16'h0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_addr();
    t_prot();
    t_idle();
    t_write();
    t_read();
    t_eop();
    t_alarm();
    t_auto();
    t_mclr();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule : tb_host_channel_coupler

// ---- verilog/hcc_bt_if.sv ----
`timescale 1ns/1ps
interface hcc_bt_if;
  logic fire_reply;
  logic fire_term;
  logic idle;
  modport core (output fire_reply, output fire_term, input idle);
  modport gen  (input fire_reply, input fire_term, output idle);
endinterface : hcc_bt_if

// ---- verilog/hcc_coupler.sv ----
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
// Contract
// - Answer an acceptable host read or write with reply within 1.2 us.
// - Answer an unacceptable host read or write with reject within 1.2 us.
// - With protect switch on, reject instructions lacking the protect line.
// - Respond only when address bits 11 to 15 are all zero.
// - Respond only when address bits 7 to 10 match the equipment switches.
// - Address bits 0 to 3 select data, control, status or autoload.
// - Director code with bits 0 and 3 prepares and carries autoload data.
// - Data transfer only for director zero; reply if possible, else reject.
// - Always reject data transfer while not ready or not busy.
// - Data interrupt on full hold for reads, empty hold for writes.
// - Reply clears data interrupt; status shows it; clear code ends transfer.
// - End interrupt enabled and cleared by code, ignores earlier completions.
// - Alarm interrupt enabled and cleared by code; per-alarm status bits.
// - Controller-side strobes are 35 to 65 ns wide.
// - Ready level high only when an immediate answer is possible.
// - Reply strobe only in answer to an output ready or input request.
// - Terminate strobe replaces reply to end a block transfer.
// - Input word stands from reply edge for the 600 ns transfer.
// - Coupler status bits set on events, cleared on input data or clear.
module hcc_coupler
  import hcc_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic        HOST_RD_IN,
  input  wire logic        HOST_WR_IN,
  input  wire logic        HOST_PROT_IN,
  input  wire logic [15:0] HOST_ADDR_IN,
  input  wire logic [15:0] HOST_DATA_IN,
  output logic      [15:0] HOST_DATA_OUT,
  output logic             HOST_DATA_OE_OUT,
  output logic             HOST_REPLY_OUT,
  output logic             HOST_REJECT_OUT,
  output logic             HOST_INT_OUT,
  input  wire logic [3:0]  EQUIP_SEL_IN,
  input  wire logic        PROTECT_SW_IN,
  input  wire logic        REPEATED_MASTER_CLEAR_IN,
  input  wire logic        OUTPUT_WORD_STROBE_IN,
  input  wire logic        INPUT_WORD_REQUEST_IN,
  input  wire logic [15:0] CTL_OUT_DATA_IN,
  input  wire logic [1:0]  CTL_OUT_PARITY_IN,
  output logic             COUPLER_READY_LEVEL_OUT,
  output logic             COUPLER_REPLY_PULSE_OUT,
  output logic             COUPLER_TERMINATE_PULSE_OUT,
  output logic      [15:0] CTL_IN_DATA_OUT,
  input  wire logic [15:0] SYS_STATUS_IN,
  input  wire logic [15:0] TRN_STATUS_IN,
  output logic      [15:0] COUPLER_STATUS_OUT
);
  localparam int SW      = 93;
  localparam int ANS_MAX = HOST_ANSWER_CYC;

  logic [SW-1:0]      raw;
  logic [SW-1:0]      syn;
  logic               rd_s, wr_s, prot_s, protsw_s, mclr_s, ows_s, iwr_s;
  logic [3:0]         equip_s;
  logic [15:0]        addr_s, hdata_s, bcdata_s, sys_s, trn_s;
  logic [1:0]         par_s;
  logic [3:0]         dir;
  hcc_host_e          host_state_r;
  logic               take, ans_reply;
  logic               en_data_r, en_eop_r, en_alarm_r;
  logic               busy_r, dir_read_r, autoload_r, perr_r;
  logic [15:0]        hold_r;
  logic               full_r;
  logic               pend_o_r, pend_i_r, ows_prev_r, iwr_prev_r;
  logic               o_rep, o_term, i_rep, i_term, o_go, i_go;
  logic               eop_pend_r, alarm_pend_r, eop_prev_r, clr_prev_r;
  logic [ALARM_W-1:0] alarm_prev_r, alarms;
  logic               full_prev_r, busy_prev_r, auto_prev_r;
  logic               data_int, ctrl_wr, clr_int, par_bad;
  logic [15:0]        status_word, cs_ev;
  logic               cs_clr;
  hcc_bt_if           bt ();

  function automatic logic hcc_selected(input logic [15:0] a,
                                        input logic [3:0]  eq);
    return (a[ADDR_CONV_MSB:ADDR_CONV_LSB] == 5'h00) &&
           (a[ADDR_EQ_MSB:ADDR_EQ_LSB] == eq);
  endfunction : hcc_selected

  // Wide data buses pass the same two stages; the far ends hold them
  // steady around their strobes, so skew between bits settles out.
  assign raw = {HOST_RD_IN, HOST_WR_IN, HOST_PROT_IN, PROTECT_SW_IN,
                REPEATED_MASTER_CLEAR_IN, OUTPUT_WORD_STROBE_IN,
                INPUT_WORD_REQUEST_IN, EQUIP_SEL_IN, HOST_ADDR_IN,
                HOST_DATA_IN, CTL_OUT_DATA_IN, CTL_OUT_PARITY_IN,
                SYS_STATUS_IN, TRN_STATUS_IN};

  hcc_sync #(.W(SW)) u_sync (
    .clk_in (CLK_IN),
    .rst_in (RESET_IN),
    .d_in   (raw),
    .q_out  (syn)
  );

  assign {rd_s, wr_s, prot_s, protsw_s, mclr_s, ows_s, iwr_s, equip_s,
          addr_s, hdata_s, bcdata_s, par_s, sys_s, trn_s} = syn;

  assign dir     = addr_s[ADDR_DIR_MSB:0];
  assign take    = (host_state_r == H_IDLE) && (rd_s || wr_s) &&
                   hcc_selected(addr_s, equip_s);
  assign ctrl_wr = take && ans_reply && wr_s && (dir == DIR_CTRL);
  assign clr_int = ctrl_wr && hdata_s[CTL_CLR_INT];
  assign alarms  = trn_s[TRN_ALARM_LSB +: ALARM_W];
  assign par_bad = !(^{bcdata_s[15:8], par_s[1]}) ||
                   !(^{bcdata_s[7:0], par_s[0]});

  always_comb
  begin
    ans_reply = 1'b0;
    if (protsw_s && !prot_s)
      ans_reply = 1'b0;
    else
    begin
      case (dir)
        DIR_DATA:
        begin
          if (!busy_r || !sys_s[SYS_READY])
            ans_reply = 1'b0;
          else if (rd_s)
            ans_reply = dir_read_r && full_r;
          else
            ans_reply = !dir_read_r && !full_r;
        end
        DIR_CTRL:     ans_reply = wr_s;
        DIR_STATUS:   ans_reply = rd_s;
        DIR_AUTOLOAD: ans_reply = wr_s && (!autoload_r || !full_r);
        default:      ans_reply = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    status_word = RST_WORD;
    status_word[ST_DATA_INT]  = data_int;
    status_word[ST_EOP_INT]   = eop_pend_r;
    status_word[ST_ALARM_INT] = alarm_pend_r;
    status_word[ST_READY]     = sys_s[SYS_READY];
    status_word[ST_BUSY]      = busy_r;
    status_word[ST_FULL]      = full_r;
    status_word[ST_AUTOLOAD]  = autoload_r;
    status_word[ST_PERR]      = perr_r;
    status_word[ST_ALARM_LSB +: ALARM_W] = alarms;
  end

  // The answer stays up until the host drops its request.
  always_ff @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      host_state_r     <= H_IDLE;
      HOST_REPLY_OUT   <= 1'b0;
      HOST_REJECT_OUT  <= 1'b0;
      HOST_DATA_OUT    <= RST_WORD;
      HOST_DATA_OE_OUT <= 1'b0;
    end
    else if (mclr_s || (host_state_r == H_HOLD && !rd_s && !wr_s))
    begin
      host_state_r     <= H_IDLE;
      HOST_REPLY_OUT   <= 1'b0;
      HOST_REJECT_OUT  <= 1'b0;
      HOST_DATA_OE_OUT <= 1'b0;
    end
    else if (take)
    begin
      host_state_r     <= H_HOLD;
      HOST_REPLY_OUT   <= ans_reply;
      HOST_REJECT_OUT  <= !ans_reply;
      HOST_DATA_OE_OUT <= rd_s && ans_reply;
      HOST_DATA_OUT    <= (dir == DIR_STATUS) ? status_word : hold_r;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN || mclr_s)
    begin
      en_data_r  <= 1'b0;
      en_eop_r   <= 1'b0;
      en_alarm_r <= 1'b0;
      busy_r     <= 1'b0;
      dir_read_r <= 1'b0;
      autoload_r <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        en_data_r  <= hdata_s[CTL_EN_DATA];
        en_eop_r   <= hdata_s[CTL_EN_EOP];
        en_alarm_r <= hdata_s[CTL_EN_ALARM];
        dir_read_r <= hdata_s[CTL_DIR_READ];
        busy_r     <= hdata_s[CTL_START] && !hdata_s[CTL_CLR_INT];
      end
      if (clr_int)
        autoload_r <= 1'b0;
      else if (take && ans_reply && wr_s && dir == DIR_AUTOLOAD)
        autoload_r <= 1'b1;
    end
  end

  // Controller side decisions: wrong direction or idle coupler terminates.
  assign o_rep  = pend_o_r && busy_r && dir_read_r && !full_r;
  assign o_term = pend_o_r && !(busy_r && dir_read_r);
  assign i_rep  = pend_i_r && busy_r && !dir_read_r && full_r;
  assign i_term = pend_i_r && !(busy_r && !dir_read_r);
  assign o_go   = bt.idle && (o_rep || o_term);
  assign i_go   = bt.idle && !o_go && (i_rep || i_term);
  assign bt.fire_reply = (o_go && o_rep) || (i_go && i_rep);
  assign bt.fire_term  = (o_go && o_term) || (i_go && i_term);

  always_ff @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN || mclr_s)
    begin
      hold_r         <= RST_WORD;
      full_r         <= 1'b0;
      perr_r         <= 1'b0;
      CTL_IN_DATA_OUT <= RST_WORD;
    end
    else if (clr_int)
      full_r <= 1'b0;
    else if (take && ans_reply && wr_s &&
             (dir == DIR_DATA || (dir == DIR_AUTOLOAD && autoload_r)))
    begin
      hold_r <= hdata_s;
      full_r <= 1'b1;
    end
    else if (take && ans_reply && rd_s && dir == DIR_DATA)
      full_r <= 1'b0;
    else if (o_go && o_rep)
    begin
      hold_r <= bcdata_s;
      full_r <= 1'b1;
      perr_r <= par_bad;
    end
    else if (i_go && i_rep)
    begin
      CTL_IN_DATA_OUT <= hold_r;
      full_r          <= 1'b0;
    end
  end

  // A leading edge is remembered until it has been answered.
  always_ff @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN || mclr_s)
    begin
      pend_o_r   <= 1'b0;
      pend_i_r   <= 1'b0;
      ows_prev_r <= 1'b0;
      iwr_prev_r <= 1'b0;
    end
    else
    begin
      ows_prev_r <= ows_s;
      iwr_prev_r <= iwr_s;
      pend_o_r   <= (ows_s && !ows_prev_r) || (pend_o_r && !o_go);
      pend_i_r   <= (iwr_s && !iwr_prev_r) || (pend_i_r && !i_go);
    end
  end

  hcc_strobe_gen u_strobe (
    .clk_in    (CLK_IN),
    .rst_in    (RESET_IN),
    .bt        (bt),
    .reply_out (COUPLER_REPLY_PULSE_OUT),
    .term_out  (COUPLER_TERMINATE_PULSE_OUT)
  );

  assign COUPLER_READY_LEVEL_OUT = busy_r && bt.idle && !pend_o_r &&
                                   !pend_i_r &&
                                   (dir_read_r ? !full_r : full_r);

  assign data_int = en_data_r && busy_r &&
                    (dir_read_r ? full_r : !full_r);
  assign HOST_INT_OUT = data_int || eop_pend_r || alarm_pend_r;

  // Only edges seen after enabling count, so stale completions are lost.
  always_ff @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN || mclr_s)
    begin
      eop_pend_r   <= 1'b0;
      alarm_pend_r <= 1'b0;
      eop_prev_r   <= 1'b0;
      alarm_prev_r <= '0;
    end
    else
    begin
      eop_prev_r   <= sys_s[SYS_EOP];
      alarm_prev_r <= alarms;
      eop_pend_r   <= (en_eop_r && ((sys_s[SYS_EOP] && !eop_prev_r) ||
                                    COUPLER_TERMINATE_PULSE_OUT)) ||
                      (eop_pend_r && !(ctrl_wr && (clr_int ||
                                       !hdata_s[CTL_EN_EOP])));
      alarm_pend_r <= (en_alarm_r && |(alarms & ~alarm_prev_r)) ||
                      (alarm_pend_r && !(ctrl_wr && (clr_int ||
                                         !hdata_s[CTL_EN_ALARM])));
    end
  end

  always_comb
  begin
    cs_ev = RST_WORD;
    cs_ev[CS_AUTOLOAD] = autoload_r && !auto_prev_r;
    cs_ev[CS_DIR_LSB +: 3] = take ? dir[2:0] : 3'h0;
    cs_ev[CS_MCLR] = mclr_s;
    cs_ev[CS_FULL] = full_r && !full_prev_r;
    cs_ev[CS_BUSY] = busy_r && !busy_prev_r;
  end

  assign cs_clr = (i_go && i_rep) || (sys_s[SYS_CLEAR] && !clr_prev_r);

  // An event in the clearing cycle survives the clear.
  always_ff @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      COUPLER_STATUS_OUT <= RST_WORD;
      full_prev_r        <= 1'b0;
      busy_prev_r        <= 1'b0;
      auto_prev_r        <= 1'b0;
      clr_prev_r         <= 1'b0;
    end
    else
    begin
      full_prev_r <= full_r;
      busy_prev_r <= busy_r;
      auto_prev_r <= autoload_r;
      clr_prev_r  <= sys_s[SYS_CLEAR];
      COUPLER_STATUS_OUT <= cs_ev |
                            (COUPLER_STATUS_OUT & ~{16{cs_clr}});
    end
  end

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN || mclr_s);

  sequence s_host_take;
    take;
  endsequence

  sequence s_reply_edge;
    $rose(COUPLER_REPLY_PULSE_OUT);
  endsequence

  AST_HOST_ANSWER: assert property (
    s_host_take |-> ##[1:ANS_MAX] (HOST_REPLY_OUT || HOST_REJECT_OUT))
    else $error("Host request not answered in time.");

  AST_PROTECT_REJECT: assert property (
    s_host_take and (protsw_s && !prot_s) |=> HOST_REJECT_OUT)
    else $error("Unprotected instruction was not rejected.");

  AST_CONVERTER_IGNORED: assert property (
    (host_state_r == H_IDLE && addr_s[ADDR_CONV_MSB:ADDR_CONV_LSB] != 5'h00)
    |=> host_state_r == H_IDLE)
    else $error("Nonzero converter field was answered.");

  AST_EQUIP_MISMATCH: assert property (
    (host_state_r == H_IDLE && addr_s[ADDR_EQ_MSB:ADDR_EQ_LSB] != equip_s)
    |=> host_state_r == H_IDLE)
    else $error("Mismatched equipment code was answered.");

  AST_DATA_NOT_BUSY: assert property (
    s_host_take and (dir == DIR_DATA && !busy_r) |=> HOST_REJECT_OUT)
    else $error("Data transfer accepted while not busy.");

  AST_STROBE_WIDTH: assert property (
    s_reply_edge |=> !COUPLER_REPLY_PULSE_OUT)
    else $error("Reply strobe longer than one clock.");

  AST_READY_LOW_IDLE: assert property (
    !busy_r |-> !COUPLER_READY_LEVEL_OUT)
    else $error("Ready level high while not busy.");

  AST_REPLY_CAUSE: assert property (
    s_reply_edge |-> $past(pend_o_r || pend_i_r))
    else $error("Reply strobe without a controller strobe.");

  AST_INPUT_HOLD: assert property (
    s_reply_edge |=> $stable(CTL_IN_DATA_OUT)[*8])
    else $error("Input word changed during its transfer.");

  AST_EOP_ENABLED: assert property (
    $rose(eop_pend_r) |-> $past(en_eop_r))
    else $error("End interrupt raised while not selected.");

endmodule : hcc_coupler

// ---- verilog/hcc_pkg.sv ----
package hcc_pkg;

  localparam int CLK_PERIOD_NS  = 40;
  localparam int HOST_ANSWER_NS = 1200;
  localparam int HOST_ANSWER_CYC = HOST_ANSWER_NS / CLK_PERIOD_NS;
  localparam int STROBE_MIN_NS  = 35;
  localparam int STROBE_MAX_NS  = 65;
  localparam int STROBE_CYC = (STROBE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
                              (STROBE_MAX_NS / CLK_PERIOD_NS);
  localparam int IN_HOLD_NS     = 600;
  localparam int IN_HOLD_CYC    = IN_HOLD_NS / CLK_PERIOD_NS;

  localparam int ADDR_DIR_MSB   = 3;
  localparam int ADDR_EQ_LSB    = 7;
  localparam int ADDR_EQ_MSB    = 10;
  localparam int ADDR_CONV_LSB  = 11;
  localparam int ADDR_CONV_MSB  = 15;

  localparam logic [3:0] DIR_DATA     = 4'h0;
  localparam logic [3:0] DIR_CTRL     = 4'h1;
  localparam logic [3:0] DIR_STATUS   = 4'h2;
  localparam logic [3:0] DIR_AUTOLOAD = 4'h9;

  localparam int CTL_EN_DATA    = 0;
  localparam int CTL_EN_EOP     = 1;
  localparam int CTL_EN_ALARM   = 2;
  localparam int CTL_CLR_INT    = 3;
  localparam int CTL_START      = 4;
  localparam int CTL_DIR_READ   = 5;

  localparam int ST_DATA_INT    = 0;
  localparam int ST_EOP_INT     = 1;
  localparam int ST_ALARM_INT   = 2;
  localparam int ST_READY       = 3;
  localparam int ST_BUSY        = 4;
  localparam int ST_FULL        = 5;
  localparam int ST_AUTOLOAD    = 6;
  localparam int ST_PERR        = 7;
  localparam int ST_ALARM_LSB   = 8;

  localparam int SYS_READY      = 0;
  localparam int SYS_EOP        = 1;
  localparam int SYS_CLEAR      = 2;
  localparam int TRN_ALARM_LSB  = 0;
  localparam int ALARM_W        = 4;

  localparam int CS_AUTOLOAD    = 0;
  localparam int CS_DIR_LSB     = 9;
  localparam int CS_MCLR        = 13;
  localparam int CS_FULL        = 14;
  localparam int CS_BUSY        = 15;

  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic {H_IDLE = 1'b0, H_HOLD = 1'b1} hcc_host_e;

endpackage : hcc_pkg

// ---- verilog/hcc_strobe_gen.sv ----
`timescale 1ns/1ps
module hcc_strobe_gen
  import hcc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  hcc_bt_if.gen     bt,
  output logic      reply_out,
  output logic      term_out
);
  logic [4:0] hold_cnt_r;
  logic       go;

  assign bt.idle = (hold_cnt_r == 5'h00);
  assign go      = bt.idle && (bt.fire_reply || bt.fire_term);

  // One clock of 40 ns lies inside the allowed strobe window.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      reply_out <= 1'b0;
      term_out  <= 1'b0;
    end
    else
    begin
      reply_out <= bt.idle && bt.fire_reply;
      term_out  <= bt.idle && bt.fire_term && !bt.fire_reply;
    end
  end

  // Blocks a new strobe until the input word has stood long enough.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      hold_cnt_r <= 5'h00;
    else if (go)
      hold_cnt_r <= 5'(IN_HOLD_CYC);
    else if (hold_cnt_r != 5'h00)
      hold_cnt_r <= hold_cnt_r - 5'h01;
  end
endmodule : hcc_strobe_gen

// ---- verilog/hcc_sync.sv ----
`timescale 1ns/1ps
module hcc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_r <= '0;
      q_out  <= '0;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule : hcc_sync
